/* hdl/ats_pkg.sv */
// Constants, register map and enumerations of the conversion trigger scheduler.
// Assumes one core clock; the register port and the conversion core share it.
// Overview of operation
// RULE1 - Serve group 2 first, then 1, then 0
// RULE2 - One-shot converts each channel one to four times
// RULE3 - Hold one retrigger per running group, drop others
// RULE4 - Drop lower group trigger during higher conversion
// RULE5 - Hold higher group trigger during lower conversion
// RULE6 - Earlier lower trigger waits until higher work ends
// RULE7 - Halt method: 0 preempts now, 1 after channel
// RULE8 - Continuous mode only group 0, repeats until stop
// RULE9 - Continuous mode ignores further group 0 triggers
// RULE10 - Source select: 1 hardware triggers, 0 software starts
// RULE11 - Ignore triggers for group with empty scan list
// RULE12 - Software start works only while converter enabled
// RULE13 - Start on next edge, set running flag then
// RULE14 - Hardware start on selected edge, 01 means rising
// RULE15 - Per-group selector picks one of sixteen sources
// RULE16 - Stop bit ends group next edge, clears flag
// RULE17 - Early stop: no end interrupt, no result write
// RULE18 - Stop after value ready still commits result
// RULE19 - After stop serve others; restart from first channel
// RULE20 - Software halts hardware triggers before stopping group
// RULE21 - Clearing enable aborts everything without storing results
// RULE22 - Stand-by clears enable; software must re-enable
// RULE23 - After stand-by, wait for stabilization counter zero
// RULE24 - End interrupt per configured channel, else group end
package ats_pkg;

  localparam int ATS_GROUPS = 3;
  localparam int ATS_CHANS = 8;
  localparam int ATS_TSEL_W = 4;
  localparam int ATS_STAB_W = 8;

  // Register byte offsets
  localparam logic [7:0] ATS_OFS_CTRL = 8'h00;
  localparam logic [7:0] ATS_OFS_TRIG = 8'h04;
  localparam logic [7:0] ATS_OFS_SCAN0 = 8'h08;
  localparam logic [7:0] ATS_OFS_IRQCFG0 = 8'h14;
  localparam logic [7:0] ATS_OFS_TSEL = 8'h20;
  localparam logic [7:0] ATS_OFS_STAB = 8'h24;
  localparam logic [7:0] ATS_OFS_STEP = 8'h04;

  // Control register fields
  localparam int ATS_CTRL_EN_BIT = 0;
  localparam int ATS_CTRL_CONT_BIT = 1;
  localparam int ATS_CTRL_HWSEL_BIT = 2;
  localparam int ATS_CTRL_HALT_BIT = 3;
  localparam int ATS_CTRL_EDGE_LSB = 4;
  localparam int ATS_CTRL_REP_LSB = 10;

  // Trigger register fields (write) and status fields (read)
  localparam int ATS_TRIG_START_LSB = 0;
  localparam int ATS_TRIG_STOP_LSB = 4;
  localparam int ATS_STAT_RUN_LSB = 0;
  localparam int ATS_STAT_PEND_LSB = 4;
  localparam int ATS_STAT_BUSY_BIT = 8;
  localparam int ATS_STAT_CUR_LSB = 9;
  localparam int ATS_STAT_STABZ_BIT = 11;

  // Reset values
  localparam logic [1:0] ATS_EDGE_RST = 2'h1;
  localparam logic [1:0] ATS_REP_RST = 2'h0;
  localparam logic [7:0] ATS_SCAN_RST = 8'h00;
  localparam logic [7:0] ATS_IRQCFG_RST = 8'h00;
  localparam logic [3:0] ATS_TSEL_RST = 4'h0;
  localparam logic [7:0] ATS_STAB_RST = 8'h00;
  localparam logic [3:0] ATS_NO_CHAN = 4'h8;

  typedef enum logic [1:0] {
    ATS_EDGE_OFF = 2'b00,
    ATS_EDGE_RISE = 2'b01,
    ATS_EDGE_FALL = 2'b10,
    ATS_EDGE_BOTH = 2'b11
  } ats_edge_e;

  typedef enum logic {
    ATS_IDLE = 1'b0,
    ATS_CONV = 1'b1
  } ats_state_e;

endpackage

/* hdl/ats_trig_if.sv */
// Carrier between the scheduler and one hardware trigger detector.
// Assumes the controller owns selection and edge code, the detector the pulse.
`timescale 1ns/1ps
interface ats_trig_if;
  logic [3:0] sel;
  logic [1:0] edge_code;
  logic pulse;
  modport det (input sel, input edge_code, output pulse);
  modport ctl (output sel, output edge_code, input pulse);
endinterface // ats_trig_if

/* hdl/ats_trig_detect.sv */
// Hardware trigger selector and edge detector for one channel group.
// Assumes its source vector is already synchronised to core_clk_i.
`timescale 1ns/1ps
module ats_trig_detect #(
  parameter int NUM_SRC = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [NUM_SRC-1:0] src_i,
  ats_trig_if.det trig_if
);
  import ats_pkg::*;

  logic lvl;
  logic prev_reg;
  logic pulse_reg;
  logic pulse_next;

  assign lvl = src_i[trig_if.sel]; // RULE15

  always_comb begin
    case (trig_if.edge_code) // RULE14
      ATS_EDGE_RISE: pulse_next = lvl & ~prev_reg;
      ATS_EDGE_FALL: pulse_next = ~lvl & prev_reg;
      ATS_EDGE_BOTH: pulse_next = lvl ^ prev_reg;
      default: pulse_next = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else if (ce_i) begin
      prev_reg <= lvl;
      pulse_reg <= pulse_next;
    end
  end

  assign trig_if.pulse = pulse_reg;
endmodule // ats_trig_detect

/* hdl/ats_stab_counter.sv */
// Stabilization down-counter reloaded when stand-by is released.
// Assumes load_i is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
module ats_stab_counter #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  output logic zero_o
);
  logic [WIDTH-1:0] cnt_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        cnt_reg <= value_i;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  assign zero_o = (cnt_reg == '0); // RULE23
endmodule // ats_stab_counter

/* hdl/adc_trigger_scheduler.sv */
// Conversion sequencer: accepts start and stop triggers, schedules groups.
// Assumes a conversion core that starts on conv_start_o, drops its work on
// conv_abort_o and pulses conv_ready_i when the digital value is ready.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module adc_trigger_scheduler #(
  parameter int NUM_SRC = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [NUM_SRC-1:0] hw_src_i,
  input wire logic standby_i,
  input wire logic conv_ready_i,
  output logic conv_start_o,
  output logic conv_abort_o,
  output logic [2:0] conv_chan_o,
  output logic [1:0] conv_group_o,
  output logic result_write_o,
  output logic [ats_pkg::ATS_GROUPS-1:0] conversion_end_irq_o,
  output logic [ats_pkg::ATS_GROUPS-1:0] group_running_flag_o
);
  import ats_pkg::*;

  // Software-visible configuration
  logic converter_enable_reg;
  logic continuous_mode_reg;
  logic trigger_source_reg;
  logic halt_method_reg;
  logic [1:0] edge_sel_reg [ATS_GROUPS];
  logic [1:0] repeat_cfg_reg [ATS_GROUPS];
  logic [7:0] scan_list_reg [ATS_GROUPS];
  logic [7:0] irq_cfg_reg [ATS_GROUPS];
  logic [3:0] tsel_reg [ATS_GROUPS];
  logic [7:0] stab_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Pin synchronisers
  logic [NUM_SRC-1:0] src_meta_reg;
  logic [NUM_SRC-1:0] src_sync_reg;
  logic stby_meta_reg;
  logic stby_sync_reg;
  logic stby_prev_reg;
  logic stby_release;
  logic stab_zero;

  // Scheduler state
  ats_state_e state_reg;
  logic [ATS_GROUPS-1:0] run_reg;
  logic [ATS_GROUPS-1:0] pend_reg;
  logic [3:0] pos_reg [ATS_GROUPS];
  logic [1:0] rep_reg [ATS_GROUPS];
  logic [1:0] cur_reg;
  logic [2:0] chan_reg;
  logic start_reg;
  logic abort_reg;
  logic commit_reg;
  logic [ATS_GROUPS-1:0] irq_reg;

  logic [ATS_GROUPS-1:0] hw_pulse;
  logic [ATS_GROUPS-1:0] sw_start;
  logic [ATS_GROUPS-1:0] sw_stop;
  logic [ATS_GROUPS-1:0] trig;
  logic [ATS_GROUPS-1:0] accept_run;
  logic [ATS_GROUPS-1:0] accept_pend;
  logic top_found;
  logic [1:0] top_grp;
  logic [3:0] ch_next;

  function automatic logic [3:0] ats_first_chan(input logic [7:0] scan,
                                                input logic [3:0] from);
    logic [3:0] r;
    r = ATS_NO_CHAN;
    for (int i = ATS_CHANS - 1; i >= 0; i--) begin
      if (scan[i] && (4'(i) >= from)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Hardware trigger path, one detector per group
  genvar g;
  generate
    for (g = 0; g < ATS_GROUPS; g++) begin : gen_trig
      ats_trig_if tif ();
      assign tif.sel = tsel_reg[g];
      assign tif.edge_code = edge_sel_reg[g];
      assign hw_pulse[g] = tif.pulse;
      ats_trig_detect #(.NUM_SRC(NUM_SRC)) u_det (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .src_i(src_sync_reg),
        .trig_if(tif.det)
      );
    end
  endgenerate

  ats_stab_counter #(.WIDTH(ATS_STAB_W)) u_stab (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .load_i(stby_release),
    .value_i(stab_reg),
    .zero_o(stab_zero)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_meta_reg <= '0;
      src_sync_reg <= '0;
      stby_meta_reg <= 1'b0;
      stby_sync_reg <= 1'b0;
      stby_prev_reg <= 1'b0;
    end else if (ce_i) begin
      src_meta_reg <= hw_src_i;
      src_sync_reg <= src_meta_reg;
      stby_meta_reg <= standby_i;
      stby_sync_reg <= stby_meta_reg;
      stby_prev_reg <= stby_sync_reg;
    end
  end

  assign stby_release = stby_prev_reg & ~stby_sync_reg;

  // Register writes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      converter_enable_reg <= 1'b0;
      continuous_mode_reg <= 1'b0;
      trigger_source_reg <= 1'b0;
      halt_method_reg <= 1'b0;
      stab_reg <= ATS_STAB_RST;
      for (int i = 0; i < ATS_GROUPS; i++) begin
        edge_sel_reg[i] <= ATS_EDGE_RST;
        repeat_cfg_reg[i] <= ATS_REP_RST;
        scan_list_reg[i] <= ATS_SCAN_RST;
        irq_cfg_reg[i] <= ATS_IRQCFG_RST;
        tsel_reg[i] <= ATS_TSEL_RST;
      end
    end else if (ce_i) begin
      if (reg_wr_i) begin
        if (reg_addr_i == ATS_OFS_CTRL) begin
          converter_enable_reg <= reg_wdata_i[ATS_CTRL_EN_BIT];
          continuous_mode_reg <= reg_wdata_i[ATS_CTRL_CONT_BIT];
          trigger_source_reg <= reg_wdata_i[ATS_CTRL_HWSEL_BIT];
          halt_method_reg <= reg_wdata_i[ATS_CTRL_HALT_BIT];
          for (int i = 0; i < ATS_GROUPS; i++) begin
            edge_sel_reg[i] <= reg_wdata_i[ATS_CTRL_EDGE_LSB + 2*i +: 2];
            repeat_cfg_reg[i] <= reg_wdata_i[ATS_CTRL_REP_LSB + 2*i +: 2];
          end
        end else if (reg_addr_i == ATS_OFS_TSEL) begin
          for (int i = 0; i < ATS_GROUPS; i++) begin
            tsel_reg[i] <= reg_wdata_i[ATS_TSEL_W*i +: ATS_TSEL_W];
          end
        end else if (reg_addr_i == ATS_OFS_STAB) begin
          stab_reg <= reg_wdata_i[7:0];
        end else begin
          for (int i = 0; i < ATS_GROUPS; i++) begin
            if (reg_addr_i == ATS_OFS_SCAN0 + 8'(i) * ATS_OFS_STEP) begin
              scan_list_reg[i] <= reg_wdata_i[7:0];
            end else if (reg_addr_i == ATS_OFS_IRQCFG0 + 8'(i) * ATS_OFS_STEP) begin
              irq_cfg_reg[i] <= reg_wdata_i[7:0];
            end
          end
        end
      end
      // Stand-by overrides any software enable in the same cycle
      if (stby_sync_reg) begin
        converter_enable_reg <= 1'b0; // RULE22
      end
    end
  end

  // Register reads
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_addr_i == ATS_OFS_CTRL) begin
      rdata_next[ATS_CTRL_EN_BIT] = converter_enable_reg;
      rdata_next[ATS_CTRL_CONT_BIT] = continuous_mode_reg;
      rdata_next[ATS_CTRL_HWSEL_BIT] = trigger_source_reg;
      rdata_next[ATS_CTRL_HALT_BIT] = halt_method_reg;
      for (int i = 0; i < ATS_GROUPS; i++) begin
        rdata_next[ATS_CTRL_EDGE_LSB + 2*i +: 2] = edge_sel_reg[i];
        rdata_next[ATS_CTRL_REP_LSB + 2*i +: 2] = repeat_cfg_reg[i];
      end
    end else if (reg_addr_i == ATS_OFS_TRIG) begin
      rdata_next[ATS_STAT_RUN_LSB +: ATS_GROUPS] = run_reg;
      rdata_next[ATS_STAT_PEND_LSB +: ATS_GROUPS] = pend_reg;
      rdata_next[ATS_STAT_BUSY_BIT] = (state_reg == ATS_CONV);
      rdata_next[ATS_STAT_CUR_LSB +: 2] = cur_reg;
      rdata_next[ATS_STAT_STABZ_BIT] = stab_zero;
    end else if (reg_addr_i == ATS_OFS_TSEL) begin
      for (int i = 0; i < ATS_GROUPS; i++) begin
        rdata_next[ATS_TSEL_W*i +: ATS_TSEL_W] = tsel_reg[i];
      end
    end else if (reg_addr_i == ATS_OFS_STAB) begin
      rdata_next[7:0] = stab_reg;
    end else begin
      for (int i = 0; i < ATS_GROUPS; i++) begin
        if (reg_addr_i == ATS_OFS_SCAN0 + 8'(i) * ATS_OFS_STEP) begin
          rdata_next[7:0] = scan_list_reg[i];
        end else if (reg_addr_i == ATS_OFS_IRQCFG0 + 8'(i) * ATS_OFS_STEP) begin
          rdata_next[7:0] = irq_cfg_reg[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_reg <= reg_rd_i ? rdata_next : 32'h0000_0000;
    end
  end

  // Trigger qualification and group priority
  always_comb begin
    top_found = 1'b0;
    top_grp = 2'h0;
    for (int i = 0; i < ATS_GROUPS; i++) begin
      sw_start[i] = reg_wr_i && (reg_addr_i == ATS_OFS_TRIG)
                    && reg_wdata_i[ATS_TRIG_START_LSB + i];
      sw_stop[i] = reg_wr_i && (reg_addr_i == ATS_OFS_TRIG)
                   && reg_wdata_i[ATS_TRIG_STOP_LSB + i];
      trig[i] = converter_enable_reg // RULE12
                && (trigger_source_reg ? hw_pulse[i] : sw_start[i]) // RULE10
                && (scan_list_reg[i] != 8'h00) // RULE11
                && !sw_stop[i];
      accept_pend[i] = trig[i] && run_reg[i] // RULE3
                       && !(i == 0 && continuous_mode_reg); // RULE9
      // A lower group is refused only while a higher one is converting
      accept_run[i] = trig[i] && !run_reg[i]
                      && !((state_reg == ATS_CONV) && (cur_reg > 2'(i))); // RULE4 RULE5
      if (run_reg[i]) begin
        top_found = 1'b1;
        top_grp = 2'(i); // RULE1
      end
    end
    ch_next = ats_first_chan(scan_list_reg[top_grp], pos_reg[top_grp]);
  end

  // Scheduler
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ATS_IDLE;
      run_reg <= '0;
      pend_reg <= '0;
      cur_reg <= 2'h0;
      chan_reg <= 3'h0;
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      commit_reg <= 1'b0;
      irq_reg <= '0;
      for (int i = 0; i < ATS_GROUPS; i++) begin
        pos_reg[i] <= 4'h0;
        rep_reg[i] <= 2'h0;
      end
    end else if (ce_i) begin
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      commit_reg <= 1'b0;
      irq_reg <= '0;
      if (!converter_enable_reg) begin
        // Disable drops everything; a value ready now is not stored
        abort_reg <= (state_reg == ATS_CONV); // RULE21
        state_reg <= ATS_IDLE;
        run_reg <= '0;
        pend_reg <= '0;
        for (int i = 0; i < ATS_GROUPS; i++) begin
          pos_reg[i] <= 4'h0;
          rep_reg[i] <= 2'h0;
        end
      end else begin
        for (int i = 0; i < ATS_GROUPS; i++) begin
          if (accept_run[i]) begin
            run_reg[i] <= 1'b1; // RULE13 RULE6
          end else if (accept_pend[i]) begin
            pend_reg[i] <= 1'b1;
          end
        end
        case (state_reg)
          ATS_IDLE: begin
            if (top_found && stab_zero) begin // RULE23
              if (ch_next != ATS_NO_CHAN) begin
                state_reg <= ATS_CONV;
                start_reg <= 1'b1;
                cur_reg <= top_grp;
                chan_reg <= ch_next[2:0];
              end else begin
                // Whole scan list done for this group
                pos_reg[top_grp] <= 4'h0;
                rep_reg[top_grp] <= 2'h0;
                irq_reg[top_grp] <= (irq_cfg_reg[top_grp] == 8'h00); // RULE24
                pend_reg[top_grp] <= pend_reg[top_grp] & accept_pend[top_grp];
                run_reg[top_grp] <= pend_reg[top_grp] | accept_pend[top_grp]
                                    | ((top_grp == 2'h0) && continuous_mode_reg); // RULE8
              end
            end
          end
          ATS_CONV: begin
            if (conv_ready_i) begin
              // Value ready wins over a stop in the same cycle
              state_reg <= ATS_IDLE;
              commit_reg <= 1'b1; // RULE18
              irq_reg[cur_reg] <= irq_cfg_reg[cur_reg][chan_reg]; // RULE24
              if (rep_reg[cur_reg] == repeat_cfg_reg[cur_reg]) begin // RULE2
                rep_reg[cur_reg] <= 2'h0;
                pos_reg[cur_reg] <= {1'b0, chan_reg} + 4'h1;
              end else begin
                rep_reg[cur_reg] <= rep_reg[cur_reg] + 2'h1;
              end
            end else if (sw_stop[cur_reg]) begin
              state_reg <= ATS_IDLE;
              abort_reg <= 1'b1; // RULE17
            end else if (top_found && (top_grp > cur_reg) && !halt_method_reg) begin
              // Interrupted channel is redone later from the same position
              state_reg <= ATS_IDLE;
              abort_reg <= 1'b1; // RULE7
            end
          end
          default: state_reg <= ATS_IDLE;
        endcase
        for (int i = 0; i < ATS_GROUPS; i++) begin
          if (sw_stop[i]) begin
            run_reg[i] <= 1'b0; // RULE16
            pend_reg[i] <= 1'b0;
            pos_reg[i] <= 4'h0; // RULE19
            rep_reg[i] <= 2'h0;
          end
        end
      end
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign conv_start_o = start_reg;
  assign conv_abort_o = abort_reg;
  assign conv_chan_o = chan_reg;
  assign conv_group_o = cur_reg;
  assign result_write_o = commit_reg;
  assign conversion_end_irq_o = irq_reg;
  assign group_running_flag_o = run_reg;
endmodule // adc_trigger_scheduler

/* bench/ats_sched_assertions.sv */
// Port-level checker for the conversion trigger scheduler.
// Assumes one clock domain and the register map of ats_pkg.
`timescale 1ns/1ps
module ats_sched_assertions
  import ats_pkg::*;
#(
  parameter int NUM_SRC = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [NUM_SRC-1:0] hw_src_i,
  input wire logic standby_i,
  input wire logic conv_ready_i,
  input wire logic conv_start_o,
  input wire logic conv_abort_o,
  input wire logic [2:0] conv_chan_o,
  input wire logic [1:0] conv_group_o,
  input wire logic result_write_o,
  input wire logic [ATS_GROUPS-1:0] conversion_end_irq_o,
  input wire logic [ATS_GROUPS-1:0] group_running_flag_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic ctl_wr;
  logic trg_wr;
  assign ctl_wr = ce_i && reg_wr_i && reg_addr_i == ATS_OFS_CTRL;
  assign trg_wr = ce_i && reg_wr_i && reg_addr_i == ATS_OFS_TRIG;

  a_stop_clears_flag: assert property (trg_wr |=>
    (group_running_flag_o & $past(reg_wdata_i[6:4])) == 3'h0) else $error("stop left flag set");
  a_disable_clears_all: assert property (ctl_wr && !reg_wdata_i[0] |-> ##2
    group_running_flag_o == 3'h0) else $error("disable left flag set");
  a_abort_no_write: assert property (conv_abort_o |-> !result_write_o)
    else $error("result written on abort");
  a_write_needs_ready: assert property (result_write_o |-> $past(conv_ready_i))
    else $error("result write without ready");
  a_start_after_flag: assert property (conv_start_o |-> $past(|group_running_flag_o))
    else $error("start without running flag");
  a_start_single_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  a_irq_near_write: assert property (|conversion_end_irq_o |->
    result_write_o || $past(result_write_o)) else $error("end irq without result");
  a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule // ats_sched_assertions

bind adc_trigger_scheduler ats_sched_assertions #(.NUM_SRC(NUM_SRC)) chk_u (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .hw_src_i(hw_src_i), .standby_i(standby_i),
  .conv_ready_i(conv_ready_i), .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
  .conv_chan_o(conv_chan_o), .conv_group_o(conv_group_o), .result_write_o(result_write_o),
  .conversion_end_irq_o(conversion_end_irq_o), .group_running_flag_o(group_running_flag_o));

/* bench/ats_core_model.sv */
// Behavioural conversion core facing the scheduler.
// Assumes start and abort are one-cycle pulses; latency set by the bench.
`timescale 1ns/1ps
module ats_core_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic conv_start_i,
  input wire logic conv_abort_i,
  input wire logic [7:0] lat_i,
  output logic conv_ready_o
);
  logic [7:0] cnt_reg;
  logic busy_reg;
  // Aborted work never reports ready, as the real core drops it
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 8'h00;
      busy_reg <= 1'b0;
      conv_ready_o <= 1'b0;
    end else begin
      conv_ready_o <= 1'b0;
      if (conv_abort_i) begin
        busy_reg <= 1'b0;
      end else if (conv_start_i) begin
        busy_reg <= 1'b1;
        cnt_reg <= lat_i;
      end else if (busy_reg && cnt_reg == 8'h00) begin
        conv_ready_o <= 1'b1;
        busy_reg <= 1'b0;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule // ats_core_model

/* bench/tb_adc_trigger_scheduler.sv */
// Self-checking bench for the conversion trigger scheduler.
// Assumes ats_core_model as conversion core and clock enable held high.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h, expected %h", $time, (a), (b)); end end
module tb_adc_trigger_scheduler;
  import ats_pkg::*;
  localparam logic [31:0] CTL_OFF = 32'h0000_0150;
  localparam logic [31:0] CTL_ON = 32'h0000_0151;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] src = 16'h0;
  logic stby = 1'b0;
  logic [7:0] lat = 8'h14;
  logic [31:0] rdata;
  logic ready, start, abort, res_wr;
  logic [2:0] chan, irq, run;
  logic [1:0] grp;
  logic [4:0] q[$];
  int error_cnt = 0;
  int tests_run = 0;
  int n_wr, n_irq, n_abort;
  int cycles = 0;

  always #12.5 clk = ~clk;

  adc_trigger_scheduler #(.NUM_SRC(16)) dut_u (
    .core_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .hw_src_i(src), .standby_i(stby),
    .conv_ready_i(ready), .conv_start_o(start), .conv_abort_o(abort), .conv_chan_o(chan),
    .conv_group_o(grp), .result_write_o(res_wr), .conversion_end_irq_o(irq),
    .group_running_flag_o(run));
  ats_core_model core_u (.core_clk_i(clk), .rst_n_i(rst_n), .conv_start_i(start),
    .conv_abort_i(abort), .lat_i(lat), .conv_ready_o(ready));

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (start) q.push_back({grp, chan});
    n_wr += int'(res_wr);
    n_irq += int'(|irq);
    n_abort += int'(abort);
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic clr;
    @(negedge clk);
    q.delete();
    n_wr = 0;
    n_irq = 0;
    n_abort = 0;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic chk_q(input logic [4:0] e[$]);
    `CHK(q.size(), e.size())
    foreach (e[i]) if (i < q.size()) `CHK(q[i], e[i])
  endtask

  task automatic s_regs;
    rd_chk(ATS_OFS_CTRL, CTL_OFF);
    rd_chk(ATS_OFS_SCAN0, 32'h0);
    wr_reg(8'h40, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0);
  endtask
  task automatic s_gate;
    wr_reg(ATS_OFS_SCAN0, 32'h1);
    wr_reg(ATS_OFS_TRIG, 32'h1);
    idle(3);
    `CHK(run, 3'h0)
    wr_reg(ATS_OFS_CTRL, CTL_ON | 32'h4);
    wr_reg(ATS_OFS_TRIG, 32'h1);
    idle(3);
    `CHK(run, 3'h0)
    wr_reg(ATS_OFS_CTRL, CTL_ON);
    wr_reg(ATS_OFS_TRIG, 32'h2);
    idle(3);
    `CHK(run, 3'h0)
  endtask
  task automatic s_oneshot;
    wr_reg(ATS_OFS_CTRL, CTL_ON | 32'h400);
    wr_reg(ATS_OFS_SCAN0, 32'h5);
    clr();
    wr_reg(ATS_OFS_TRIG, 32'h1);
    #1 `CHK(run, 3'h1)
    `CHK(q.size(), 0)
    idle(150);
    chk_q('{5'h00, 5'h00, 5'h02, 5'h02});
    `CHK(n_wr, 4)
    `CHK(n_irq, 1)
    wr_reg(ATS_OFS_IRQCFG0, 32'h4);
    clr();
    wr_reg(ATS_OFS_TRIG, 32'h1);
    idle(150);
    `CHK(n_irq, 2)
  endtask
  task automatic preempt(input int n_exp);
    clr();
    wr_reg(ATS_OFS_TRIG, 32'h1);
    idle(5);
    wr_reg(ATS_OFS_TRIG, 32'h4);
    idle(90);
    if (n_exp == 1) chk_q('{5'h00, 5'h12, 5'h00});
    else chk_q('{5'h00, 5'h12});
    `CHK(n_abort, n_exp)
  endtask
  task automatic s_prio;
    wr_reg(ATS_OFS_CTRL, CTL_ON);
    wr_reg(ATS_OFS_SCAN0, 32'h1);
    wr_reg(ATS_OFS_SCAN0 + ATS_OFS_STEP, 32'h2);
    wr_reg(ATS_OFS_SCAN0 + 8'h08, 32'h4);
    clr();
    wr_reg(ATS_OFS_TRIG, 32'h5);
    idle(3);
    wr_reg(ATS_OFS_TRIG, 32'h2);
    idle(80);
    chk_q('{5'h12, 5'h00});
    preempt(1);
    wr_reg(ATS_OFS_CTRL, CTL_ON | 32'h8);
    preempt(0);
    clr();
    wr_reg(ATS_OFS_TRIG, 32'h1);
    idle(3);
    wr_reg(ATS_OFS_TRIG, 32'h1);
    wr_reg(ATS_OFS_TRIG, 32'h1);
    idle(80);
    chk_q('{5'h00, 5'h00});
  endtask
  task automatic s_stop;
    wr_reg(ATS_OFS_SCAN0, 32'h6);
    clr();
    wr_reg(ATS_OFS_TRIG, 32'h1);
    idle(5);
    wr_reg(ATS_OFS_TRIG, 32'h10);
    #1 `CHK(run, 3'h0)
    idle(30);
    `CHK(n_wr + n_irq, 0)
    `CHK(n_abort, 1)
    wr_reg(ATS_OFS_TRIG, 32'h1);
    idle(80);
    chk_q('{5'h01, 5'h01, 5'h02});
  endtask
  task automatic s_cont;
    wr_reg(ATS_OFS_SCAN0, 32'h1);
    wr_reg(ATS_OFS_CTRL, CTL_ON | 32'h2);
    clr();
    wr_reg(ATS_OFS_TRIG, 32'h1);
    idle(3);
    wr_reg(ATS_OFS_TRIG, 32'h1);
    rd_chk(ATS_OFS_TRIG, 32'h901);
    idle(100);
    `CHK(q.size() >= 3, 1'b1)
    wr_reg(ATS_OFS_TRIG, 32'h10);
    idle(30);
    clr();
    idle(60);
    `CHK(q.size(), 0)
    `CHK(run, 3'h0)
  endtask
  task automatic s_hw;
    wr_reg(ATS_OFS_CTRL, CTL_ON | 32'h4);
    wr_reg(ATS_OFS_TSEL, 32'h3);
    @(posedge clk) src <= 16'h0020;
    idle(10);
    `CHK(run, 3'h0)
    @(posedge clk) src <= 16'h0008;
    idle(8);
    `CHK(run, 3'h1)
    @(posedge clk) src <= 16'h0000;
    wr_reg(ATS_OFS_TRIG, 32'h10);
    idle(2);
    `CHK(run, 3'h0)
  endtask
  task automatic s_standby;
    wr_reg(ATS_OFS_CTRL, CTL_ON);
    wr_reg(ATS_OFS_STAB, 32'h20);
    clr();
    wr_reg(ATS_OFS_TRIG, 32'h1);
    idle(5);
    wr_reg(ATS_OFS_CTRL, CTL_OFF);
    idle(1);
    #1 `CHK(run, 3'h0)
    idle(30);
    `CHK(n_wr, 0)
    `CHK(n_abort, 1)
    wr_reg(ATS_OFS_CTRL, CTL_ON);
    @(posedge clk) stby <= 1'b1;
    idle(6);
    rd_chk(ATS_OFS_CTRL, CTL_OFF);
    @(posedge clk) stby <= 1'b0;
    idle(3);
    wr_reg(ATS_OFS_CTRL, CTL_ON);
    clr();
    wr_reg(ATS_OFS_TRIG, 32'h1);
    idle(6);
    `CHK(q.size(), 0)
    idle(80);
    chk_q('{5'h00});
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_gate();
    s_oneshot();
    s_prio();
    s_stop();
    s_cont();
    s_hw();
    s_standby();
    stop_test();
  end
endmodule // tb_adc_trigger_scheduler
